// ---- src/ocad_params.svh ----
// constants of the on-chip address decoder: windows, enable bits, timing
`ifndef OCAD_PARAMS_SVH
`define OCAD_PARAMS_SVH

// flash bank, user mode
`define OCAD_FLASH_SEC0_BASE 24'h000000
`define OCAD_FLASH_SEC0_LAST 24'h001FFF
`define OCAD_FLASH_SEC3_LAST 24'h007FFF
`define OCAD_TEST_SECTOR_OFFSET 24'h100000
`define OCAD_FLASH_SEC4_BASE 24'h018000
`define OCAD_FLASH_SEC5_BASE 24'h020000
`define OCAD_FLASH_SEC5_LAST 24'h02FFFF
`define OCAD_FLASH_HIGH_LAST 24'h04FFFF
`define OCAD_FLASH_SEC_8K_MASK 24'h001FFF
// special function register areas, two 512-byte blocks
`define OCAD_SFR_BASE 24'h00FE00
`define OCAD_EXTENDED_SPECIAL_FUNCTION_REGISTERS_BASE 24'h00F000
`define OCAD_SFR_AREA_MASK 24'hFFFE00
// extension ram
`define OCAD_RAM1_BASE 24'h00E000
`define OCAD_RAM1_LAST 24'h00E7FF
`define OCAD_RAM2_BASE_RESET 8'h09
`define OCAD_RAM2_MIRROR_BITS 14
// expansion bus peripheral windows (256 byte each)
`define OCAD_CAN1_BASE 24'h00EF00
`define OCAD_CAN2_BASE 24'h00EE00
`define OCAD_RTC_BASE 24'h00ED00
`define OCAD_PWM_BASE 24'h00EC00
`define OCAD_MISC_BASE 24'h00EB00
`define OCAD_I2C_BASE 24'h00EA00
`define OCAD_ASC_BASE 24'h00E900
`define OCAD_SSC_BASE 24'h00E800
`define OCAD_PERIPH_MASK 24'hFFFF00
// enable bit positions
`define OCAD_GLOBAL_EN_BIT 2
`define OCAD_EN_CAN1 0
`define OCAD_EN_CAN2 1
`define OCAD_EN_RAM1 2
`define OCAD_EN_RAM2 3
`define OCAD_EN_RTC 4
`define OCAD_EN_PWM 6
`define OCAD_EN_ASC 7
`define OCAD_EN_SSC 8
`define OCAD_EN_I2C 9
`define OCAD_EN_MISC 10
// segment lines
`define OCAD_SEG_LINES_FULL 4'h8
`define OCAD_SEG_LINES_CAN 4'h4
// timing: peripheral access 62.5 ns, clock 125 MHz; wait-state counts are set directly, not derived from it
`define OCAD_CLK_PERIOD_PS 8000
`define OCAD_PERIPH_ACCESS_PS 62500
`define OCAD_RAM_WAIT_STATES 0
`define OCAD_PERIPH_WAIT_STATES 2

`endif

// ---- src/ocad_pkg.sv ----
// types of the on-chip address decoder
package ocad_pkg;

	typedef enum logic [4:0] {
		OCAD_TGT_FLASH = 5'h00,
		OCAD_TGT_SFR = 5'h01,
		OCAD_TGT_RAM1 = 5'h02,
		OCAD_TGT_RAM2 = 5'h03,
		OCAD_TGT_CAN1 = 5'h04,
		OCAD_TGT_CAN2 = 5'h05,
		OCAD_TGT_RTC = 5'h06,
		OCAD_TGT_PWM = 5'h07,
		OCAD_TGT_ASC = 5'h08,
		OCAD_TGT_SSC = 5'h09,
		OCAD_TGT_I2C = 5'h0A,
		OCAD_TGT_MISC = 5'h0B,
		OCAD_TGT_EXT = 5'h0C
	} ocad_target_t;

	typedef enum logic [2:0] {
		OCAD_ST_IDLE = 3'b001,
		OCAD_ST_WAIT = 3'b010,
		OCAD_ST_DONE = 3'b100
	} ocad_state_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic word;
		logic [23:0] addr;
		logic [15:0] wdata;
	} ocad_req_t;

	typedef struct packed {
		ocad_target_t target;
		logic [23:0] local_addr;
		logic word_only;
		logic [1:0] wait_states;
	} ocad_route_t;

	typedef struct packed {
		ocad_state_t state;
		ocad_route_t route;
		ocad_req_t req;
		logic [1:0] wait_cnt;
		logic [15:0] rdata;
		logic size_err;
		logic [7:0] ram2_base;
	} ocad_state_vec_t;

endpackage : ocad_pkg

// ---- src/ocad_window.sv ----
// one enabled peripheral window compare
`timescale 1ns/10ps
`default_nettype none

module ocad_window
	import ocad_pkg::*;
#(
	parameter logic [23:0] BASE = 24'h000000,
	parameter logic [23:0] MASK = 24'hFFFF00
)
(
	input wire logic [23:0] addr,
	input wire logic global_en,
	input wire logic local_en,
	output logic hit
);

	assign hit = global_en && local_en && ((addr & MASK) == BASE);

endmodule // ocad_window

`default_nettype wire

// ---- src/ocad_ram2_map.sv ----
// second extension ram window and mirror reduction
`timescale 1ns/10ps
`default_nettype none
`include "ocad_params.svh"

module ocad_ram2_map
	import ocad_pkg::*;
#(
	parameter int RAM_ADDR_BITS = 13
)
(
	input wire logic [23:0] addr,
	input wire logic [7:0] base_segment,
	input wire logic global_en,
	input wire logic ram_en,
	output logic hit,
	output logic [23:0] local_addr
);

	// region is one 64K segment; the ram repeats every 8K inside it
	assign hit = global_en && ram_en && (addr[23:16] == base_segment);
	assign local_addr = {{(24 - RAM_ADDR_BITS){1'b0}},
		addr[RAM_ADDR_BITS-1:0]};

endmodule // ocad_ram2_map

`default_nettype wire

// ---- src/ocad_decoder.sv ----
// on-chip address decoder: routes cpu accesses to on-chip targets
`timescale 1ns/10ps
`default_nettype none
`include "ocad_params.svh"

module ocad_decoder
	import ocad_pkg::*;
#(
	parameter int RAM2_ADDR_BITS = 13
)
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire ocad_req_t cpu_req,
	output logic cpu_ready,
	output logic [15:0] cpu_rdata,
	output logic cpu_size_err,
	input wire logic bootstrap_mode,
	input wire logic global_expansion_enable,
	input wire logic [15:0] peripheral_enable_register,
	input wire logic ram2_base_load,
	input wire logic [7:0] second_ram_base_select,
	output logic [7:0] ram2_base,
	output ocad_route_t route,
	output logic route_valid,
	output logic route_write,
	output logic route_word,
	output logic [15:0] route_wdata,
	input wire logic [15:0] target_rdata,
	input wire logic ext_ready,
	output logic [3:0] segment_lines
);

	// ==========================================================
	// window compares
	logic [15:0] pe;
	logic gx;
	logic hit_can1;
	logic hit_can2;
	logic hit_rtc;
	logic hit_pwm;
	logic hit_asc;
	logic hit_ssc;
	logic hit_i2c;
	logic hit_misc;
	logic hit_ram2;
	logic [23:0] ram2_local;
	ocad_state_vec_t cur;
	ocad_state_vec_t next_cur;
	ocad_route_t dec;

	assign pe = peripheral_enable_register;
	assign gx = global_expansion_enable;

	ocad_window #(.BASE(`OCAD_CAN1_BASE), .MASK(`OCAD_PERIPH_MASK)) u_can1
	(
		.addr(cpu_req.addr), .global_en(gx),
		.local_en(pe[`OCAD_EN_CAN1]), .hit(hit_can1)
	);
	ocad_window #(.BASE(`OCAD_CAN2_BASE), .MASK(`OCAD_PERIPH_MASK)) u_can2
	(
		.addr(cpu_req.addr), .global_en(gx),
		.local_en(pe[`OCAD_EN_CAN2]), .hit(hit_can2)
	);
	ocad_window #(.BASE(`OCAD_RTC_BASE), .MASK(`OCAD_PERIPH_MASK)) u_rtc
	(
		.addr(cpu_req.addr), .global_en(gx),
		.local_en(pe[`OCAD_EN_RTC]), .hit(hit_rtc)
	);
	ocad_window #(.BASE(`OCAD_PWM_BASE), .MASK(`OCAD_PERIPH_MASK)) u_pwm
	(
		.addr(cpu_req.addr), .global_en(gx),
		.local_en(pe[`OCAD_EN_PWM]), .hit(hit_pwm)
	);
	ocad_window #(.BASE(`OCAD_ASC_BASE), .MASK(`OCAD_PERIPH_MASK)) u_asc
	(
		.addr(cpu_req.addr), .global_en(gx),
		.local_en(pe[`OCAD_EN_ASC]), .hit(hit_asc)
	);
	ocad_window #(.BASE(`OCAD_SSC_BASE), .MASK(`OCAD_PERIPH_MASK)) u_ssc
	(
		.addr(cpu_req.addr), .global_en(gx),
		.local_en(pe[`OCAD_EN_SSC]), .hit(hit_ssc)
	);
	ocad_window #(.BASE(`OCAD_I2C_BASE), .MASK(`OCAD_PERIPH_MASK)) u_i2c
	(
		.addr(cpu_req.addr), .global_en(gx),
		.local_en(pe[`OCAD_EN_I2C]), .hit(hit_i2c)
	);
	ocad_window #(.BASE(`OCAD_MISC_BASE), .MASK(`OCAD_PERIPH_MASK)) u_misc
	(
		.addr(cpu_req.addr), .global_en(gx),
		.local_en(pe[`OCAD_EN_MISC]), .hit(hit_misc)
	);

	ocad_ram2_map #(.RAM_ADDR_BITS(RAM2_ADDR_BITS)) u_ram2
	(
		.addr(cpu_req.addr),
		.base_segment(cur.ram2_base),
		.global_en(gx),
		.ram_en(pe[`OCAD_EN_RAM2]),
		.hit(hit_ram2),
		.local_addr(ram2_local)
	);

	// ==========================================================
	// address decode, highest priority first
	function automatic ocad_route_t periph(ocad_target_t t,
		logic [23:0] a);
		ocad_route_t r;
		r.target = t;
		r.local_addr = {16'h0000, a[7:0]};
		r.word_only = 1'b1;
		r.wait_states = 2'(`OCAD_PERIPH_WAIT_STATES);
		return r;
	endfunction

	always_comb
	begin
		logic [23:0] a;
		a = cpu_req.addr;
		// default: external interface, disabled windows fall here
		dec.target = OCAD_TGT_EXT;
		dec.local_addr = a;
		dec.word_only = 1'b0;
		dec.wait_states = 2'h0;
		// the hole between the 8K and 32K sectors is not flash
		if (a <= `OCAD_FLASH_SEC3_LAST ||
			(a >= `OCAD_FLASH_SEC4_BASE && a <= `OCAD_FLASH_HIGH_LAST))
		begin
			// sectors six and seven are decoded as flash too
			dec.target = OCAD_TGT_FLASH;
			dec.local_addr = a;
			if (bootstrap_mode && a <= `OCAD_FLASH_SEC0_LAST)
				// test sector lives above the user bank
				dec.local_addr = a | `OCAD_TEST_SECTOR_OFFSET;
		end
		else if ((a & `OCAD_SFR_AREA_MASK) == `OCAD_SFR_BASE ||
			(a & `OCAD_SFR_AREA_MASK) == `OCAD_EXTENDED_SPECIAL_FUNCTION_REGISTERS_BASE)
		begin
			dec.target = OCAD_TGT_SFR;
			dec.word_only = 1'b0;
		end
		else if (hit_can1)
			dec = periph(OCAD_TGT_CAN1, a);
		else if (hit_can2)
			dec = periph(OCAD_TGT_CAN2, a);
		else if (hit_rtc)
			dec = periph(OCAD_TGT_RTC, a);
		else if (hit_pwm)
			dec = periph(OCAD_TGT_PWM, a);
		else if (hit_asc)
			dec = periph(OCAD_TGT_ASC, a);
		else if (hit_ssc)
			dec = periph(OCAD_TGT_SSC, a);
		else if (hit_i2c)
			dec = periph(OCAD_TGT_I2C, a);
		else if (hit_misc)
			dec = periph(OCAD_TGT_MISC, a);
		else if (gx && pe[`OCAD_EN_RAM1] && a >= `OCAD_RAM1_BASE &&
			a <= `OCAD_RAM1_LAST)
		begin
			dec.target = OCAD_TGT_RAM1;
			dec.local_addr = a - `OCAD_RAM1_BASE;
			dec.wait_states = 2'(`OCAD_RAM_WAIT_STATES);
		end
		else if (hit_ram2)
		begin
			dec.target = OCAD_TGT_RAM2;
			dec.local_addr = ram2_local;
			dec.wait_states = 2'(`OCAD_RAM_WAIT_STATES);
		end
	end

	// ==========================================================
	// access sequencer
	always_comb
	begin
		next_cur = cur;
		next_cur.size_err = 1'b0;
		if (ram2_base_load)
			next_cur.ram2_base = second_ram_base_select;
		unique case (cur.state)
			OCAD_ST_IDLE:
			begin
				if (cpu_req.valid)
				begin
					next_cur.req = cpu_req;
					next_cur.route = dec;
					next_cur.wait_cnt = dec.wait_states;
					// byte access to a word-only peripheral is refused
					if (dec.word_only && !cpu_req.word)
					begin
						next_cur.size_err = 1'b1;
						next_cur.state = OCAD_ST_DONE;
						next_cur.rdata = 16'h0000;
					end
					else
						next_cur.state = OCAD_ST_WAIT;
				end
			end
			OCAD_ST_WAIT:
			begin
				if (cur.wait_cnt != 2'h0)
					next_cur.wait_cnt = cur.wait_cnt - 2'h1;
				else if (cur.route.target != OCAD_TGT_EXT || ext_ready)
				begin
					next_cur.rdata = cur.req.word ? target_rdata :
						{8'h00, target_rdata[7:0]};
					next_cur.state = OCAD_ST_DONE;
				end
			end
			OCAD_ST_DONE:
			begin
				next_cur.state = OCAD_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cur <= '{state: OCAD_ST_IDLE,
				route: '{target: OCAD_TGT_EXT, local_addr: 24'h000000,
				word_only: 1'b0, wait_states: 2'h0},
				req: '0, wait_cnt: 2'h0, rdata: 16'h0000,
				size_err: 1'b0,
				ram2_base: `OCAD_RAM2_BASE_RESET};
		end
		else
			cur <= next_cur;
	end

	// ==========================================================
	// outputs
	assign cpu_ready = (cur.state == OCAD_ST_DONE);
	assign cpu_rdata = cur.rdata;
	assign cpu_size_err = cur.size_err;
	assign ram2_base = cur.ram2_base;
	assign route = cur.route;
	assign route_valid = (cur.state == OCAD_ST_WAIT);
	assign route_write = cur.req.write;
	assign route_word = cur.req.word;
	assign route_wdata = cur.req.wdata;
	// no bit-addressable path exists for ram targets
	assign segment_lines = (gx && (pe[`OCAD_EN_CAN1] || pe[`OCAD_EN_CAN2])) ?
		`OCAD_SEG_LINES_CAN : `OCAD_SEG_LINES_FULL;

	// ==========================================================
	// checks
	property p_periph_wait;
		@(posedge mclk) disable iff (!arst_n)
		(cur.state == OCAD_ST_IDLE && cpu_req.valid && dec.word_only &&
		cpu_req.word) |=> route_valid [*3] ##1 cpu_ready;
	endproperty
	a_periph_wait: assert property (p_periph_wait)
		else $error("peripheral access not three cycles");

	property p_ram_zero_wait;
		@(posedge mclk) disable iff (!arst_n)
		(cur.state == OCAD_ST_IDLE && cpu_req.valid &&
		(dec.target == OCAD_TGT_RAM1 || dec.target == OCAD_TGT_RAM2))
		|=> ##1 cpu_ready;
	endproperty
	a_ram_zero_wait: assert property (p_ram_zero_wait)
		else $error("ram access has wait states");

	property p_ram1_enable;
		@(posedge mclk) disable iff (!arst_n)
		(dec.target == OCAD_TGT_RAM1) |-> (gx && pe[`OCAD_EN_RAM1]);
	endproperty
	a_ram1_enable: assert property (p_ram1_enable)
		else $error("first ram decoded while disabled");

	property p_ram1_ext;
		@(posedge mclk) disable iff (!arst_n)
		(!gx && cpu_req.addr >= `OCAD_RAM1_BASE &&
		cpu_req.addr <= `OCAD_RAM1_LAST) |-> dec.target == OCAD_TGT_EXT;
	endproperty
	a_ram1_ext: assert property (p_ram1_ext)
		else $error("disabled first ram not external");

	property p_can_enable;
		@(posedge mclk) disable iff (!arst_n)
		(dec.target == OCAD_TGT_CAN1) |-> (gx && pe[`OCAD_EN_CAN1]);
	endproperty
	a_can_enable: assert property (p_can_enable)
		else $error("first can decoded while disabled");

	property p_flash_low;
		@(posedge mclk) disable iff (!arst_n)
		(cpu_req.addr <= `OCAD_FLASH_SEC3_LAST ||
		(cpu_req.addr >= `OCAD_FLASH_SEC4_BASE &&
		cpu_req.addr <= `OCAD_FLASH_HIGH_LAST)) |->
		dec.target == OCAD_TGT_FLASH;
	endproperty
	a_flash_low: assert property (p_flash_low)
		else $error("flash range not routed to flash");

	property p_size_err;
		@(posedge mclk) disable iff (!arst_n)
		(cur.state == OCAD_ST_IDLE && cpu_req.valid && dec.word_only &&
		!cpu_req.word) |=> cpu_ready && cpu_size_err;
	endproperty
	a_size_err: assert property (p_size_err)
		else $error("byte access to peripheral not refused");

	property p_seg_lines;
		@(posedge mclk) disable iff (!arst_n)
		(gx && pe[`OCAD_EN_CAN2]) |-> segment_lines == `OCAD_SEG_LINES_CAN;
	endproperty
	a_seg_lines: assert property (p_seg_lines)
		else $error("segment lines not limited");

	property p_ram2_base_hold;
		@(posedge mclk) disable iff (!arst_n)
		!ram2_base_load |=> ram2_base == $past(ram2_base);
	endproperty
	a_ram2_base_hold: assert property (p_ram2_base_hold)
		else $error("second ram base changed without load");

	c_ram2: cover property (@(posedge mclk) disable iff (!arst_n)
		dec.target == OCAD_TGT_RAM2 && cpu_req.valid);
	c_can1: cover property (@(posedge mclk) disable iff (!arst_n)
		route_valid && route.target == OCAD_TGT_CAN1);
	c_ext: cover property (@(posedge mclk) disable iff (!arst_n)
		route_valid && route.target == OCAD_TGT_EXT ##1 !ext_ready);
	c_boot: cover property (@(posedge mclk) disable iff (!arst_n)
		bootstrap_mode && cpu_req.valid && cpu_req.addr == 24'h000000);

endmodule // ocad_decoder

`default_nettype wire

// ---- tb/ocad_target_model.sv ----
// far-side model: targets and external interface answering routed accesses
`timescale 1ns/10ps
`default_nettype none
module ocad_target_model import ocad_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire ocad_route_t route,
	input wire logic route_valid,
	input wire logic [3:0] ext_delay,
	output logic [15:0] target_rdata,
	output logic ext_ready
);
	// ==========
	// answer
	logic [3:0] cnt;
	logic [15:0] last;
	logic on;
	assign on = route_valid && route.target == OCAD_TGT_EXT;
	// data names the answering target; released bus toggles every cycle
	assign target_rdata = route_valid ? {11'h5A3, route.target} : ~last;
	// slow external cycle stretches by ext_delay cycles
	assign ext_ready = on && cnt >= ext_delay;
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt <= 4'h0;
			last <= 16'h0000;
		end
		else
		begin
			cnt <= on ? cnt + 4'h1 : 4'h0;
			last <= target_rdata;
		end
	end
endmodule // ocad_target_model
`default_nettype wire

// ---- tb/ocad_decoder_tb.sv ----
// self-checking bench of the on-chip address decoder
`timescale 1ns/10ps
`default_nettype none
module ocad_decoder_tb import ocad_pkg::*;
;
	// ==========
	// signals
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	ocad_req_t cpu_req = '0;
	logic cpu_ready, cpu_size_err, route_valid, route_write, route_word;
	logic [15:0] cpu_rdata, route_wdata, target_rdata;
	logic bootstrap_mode = 1'b0;
	logic global_expansion_enable = 1'b0;
	logic [15:0] peripheral_enable_register = 16'h0000;
	logic ram2_base_load = 1'b0;
	logic [7:0] second_ram_base_select = 8'h00;
	logic [7:0] ram2_base;
	logic [3:0] segment_lines;
	logic [3:0] ext_delay = 4'h0;
	logic ext_ready;
	ocad_route_t route;
	int errors = 0;
	int checked = 0;
	int lat;
	logic [4:0] got_t;
	logic [23:0] got_la;
	logic [15:0] got_wd;
	logic [1:0] got_ww;
	ocad_route_t got_ro;
	localparam logic [23:0] PB [8] = '{24'h00EF00, 24'h00EE00, 24'h00ED00,
		24'h00EC00, 24'h00E900, 24'h00E800, 24'h00EA00, 24'h00EB00};
	localparam int PE [8] = '{0, 1, 4, 6, 7, 8, 9, 10};
	localparam ocad_target_t PT [8] = '{OCAD_TGT_CAN1, OCAD_TGT_CAN2,
		OCAD_TGT_RTC, OCAD_TGT_PWM, OCAD_TGT_ASC, OCAD_TGT_SSC,
		OCAD_TGT_I2C, OCAD_TGT_MISC};
	always #4 mclk = ~mclk;
	ocad_decoder ocad_decoder_i (.mclk, .arst_n, .cpu_req, .cpu_ready,
		.cpu_rdata, .cpu_size_err, .bootstrap_mode, .global_expansion_enable,
		.peripheral_enable_register, .ram2_base_load,
		.second_ram_base_select, .ram2_base, .route, .route_valid,
		.route_write, .route_word, .route_wdata, .target_rdata, .ext_ready,
		.segment_lines);
	ocad_target_model ocad_target_model_i (.mclk, .arst_n, .route,
		.route_valid, .ext_delay, .target_rdata, .ext_ready);
	// ==========
	// helpers
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// request stays up until the answer; the caller replaces or drops it
	task automatic acc(input logic [23:0] a, input logic wr, input logic wd);
		int n;
		// the edge that launches the request counts as the first
		n = 1;
		got_t = 5'h1F;
		cpu_req <= '{1'b1, wr, wd, a, 16'hC35A};
		do
		begin
			@(posedge mclk);
			n++;
			if (route_valid === 1'b1)
			begin
				got_t = route.target;
				got_la = route.local_addr;
				got_wd = route_wdata;
				got_ww = {route_write, route_word};
				got_ro = route;
			end
		end
		while (cpu_ready !== 1'b1 && n < 40);
		if (n >= 40)
		begin
			errors++;
			close_out();
		end
		lat = n;
	endtask
	// l of zero means an external cycle of ext_delay extra cycles
	task automatic go(input logic [23:0] a, input logic wd,
		input ocad_target_t t, input int l);
		acc(a, 1'b0, wd);
		if (l == 0)
			chk(24'(lat), 24'(4 + ext_delay));
		else
			chk(24'(lat), 24'(l));
		chk(cpu_size_err, 1'b0);
		chk(got_t, t);
		chk(got_ww, {1'b0, wd});
		chk(cpu_rdata, wd ? {11'h5A3, t} : {8'h00, 3'h3, t});
	endtask
	task automatic cfg(input logic g, input logic [15:0] p);
		cpu_req.valid <= 1'b0;
		global_expansion_enable <= g;
		peripheral_enable_register <= p;
		@(posedge mclk);
	endtask
	// ==========
	// scenarios
	task automatic t_flash();
		chk(segment_lines, 4'h8);
		go(24'h000000, 1'b1, OCAD_TGT_FLASH, 4);
		go(24'h001FFF, 1'b0, OCAD_TGT_FLASH, 4);
		go(24'h02FFFF, 1'b1, OCAD_TGT_FLASH, 4);
		go(24'h04FFFF, 1'b0, OCAD_TGT_FLASH, 4);
		go(24'h008000, 1'b1, OCAD_TGT_EXT, 0);
		go(24'h050000, 1'b1, OCAD_TGT_EXT, 0);
		go(24'h000010, 1'b1, OCAD_TGT_FLASH, 4);
		chk(got_la[20], 1'b0);
		cfg(1'b0, 16'h0000);
		bootstrap_mode <= 1'b1;
		go(24'h000010, 1'b1, OCAD_TGT_FLASH, 4);
		chk(got_la, 24'h100010);
		cfg(1'b0, 16'h0000);
		bootstrap_mode <= 1'b0;
		ext_delay <= 4'h6;
		go(24'h00F200, 1'b1, OCAD_TGT_EXT, 0);
		ext_delay <= 4'h0;
		go(24'h00F000, 1'b1, OCAD_TGT_SFR, 4);
		go(24'h00F1FF, 1'b0, OCAD_TGT_SFR, 4);
		go(24'h00FE00, 1'b1, OCAD_TGT_SFR, 4);
		go(24'h00FFFF, 1'b1, OCAD_TGT_SFR, 4);
	endtask
	task automatic t_ram1();
		cfg(1'b1, 16'h0004);
		go(24'h00E000, 1'b1, OCAD_TGT_RAM1, 4);
		go(24'h00E7FF, 1'b0, OCAD_TGT_RAM1, 4);
		acc(24'h00E002, 1'b1, 1'b1);
		chk(24'(lat), 24'd4);
		chk(got_wd, 16'hC35A);
		chk(got_ww, 2'b11);
		chk(got_ro.wait_states, 2'h0);
		cfg(1'b1, 16'hFFFB);
		go(24'h00E000, 1'b1, OCAD_TGT_EXT, 0);
		cfg(1'b0, 16'h0004);
		go(24'h00E7FF, 1'b1, OCAD_TGT_EXT, 0);
	endtask
	task automatic t_periph();
		for (int i = 0; i < 8; i++)
		begin
			cfg(1'b1, 16'h0001 << PE[i]);
			go(PB[i], 1'b1, PT[i], 6);
			go(PB[i] + 24'hFF, 1'b1, PT[i], 6);
			chk(got_ro.word_only, 1'b1);
			chk(got_ro.wait_states, 2'h2);
			acc(PB[i], 1'b0, 1'b0);
			chk(24'(lat), 24'd3);
			chk(cpu_size_err, 1'b1);
			cfg(1'b1, ~(16'h0001 << PE[i]));
			chk(cpu_size_err, 1'b0);
			go(PB[i], 1'b1, OCAD_TGT_EXT, 0);
			cfg(1'b0, 16'hFFFF);
			go(PB[i] + 24'h80, 1'b1, OCAD_TGT_EXT, 0);
		end
	endtask
	task automatic t_ram2();
		logic [23:0] la;
		chk(ram2_base, 8'h09);
		cfg(1'b1, 16'h0008);
		go(24'h090010, 1'b1, OCAD_TGT_RAM2, 4);
		la = got_la;
		go(24'h094010, 1'b1, OCAD_TGT_RAM2, 4);
		chk(got_la, la);
		cfg(1'b0, 16'h0008);
		go(24'h090010, 1'b1, OCAD_TGT_EXT, 0);
		cfg(1'b1, 16'h0008);
		ram2_base_load <= 1'b1;
		second_ram_base_select <= 8'h0A;
		@(posedge mclk);
		ram2_base_load <= 1'b0;
		@(posedge mclk);
		chk(ram2_base, 8'h0A);
		go(24'h0A2000, 1'b1, OCAD_TGT_RAM2, 4);
		go(24'h090010, 1'b1, OCAD_TGT_EXT, 0);
		cfg(1'b1, 16'h0002);
		chk(segment_lines, 4'h4);
		cfg(1'b1, 16'hFFFC);
		chk(segment_lines, 4'h8);
		cfg(1'b0, 16'h0001);
		chk(segment_lines, 4'h8);
		arst_n <= 1'b0;
		@(posedge mclk);
		chk(cpu_ready, 1'b0);
		chk(ram2_base, 8'h09);
		arst_n <= 1'b1;
		@(posedge mclk);
	endtask
	initial
	begin
		repeat (8) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		t_flash();
		t_ram1();
		t_periph();
		t_ram2();
		close_out();
	end
endmodule // ocad_decoder_tb
`default_nettype wire
